// >>> shared/sldc_consts.svh
// offsets, field positions, reset values for the lane driver register bank
`ifndef SLDC_CONSTS_SVH
`define SLDC_CONSTS_SVH

// register indices; byte address is four times the index
`define SLDC_IDX_SWING6 14'h05C3
`define SLDC_IDX_DE_BASE 14'h05C4
`define SLDC_IDX_DE_LANE0 14'h05C4
`define SLDC_IDX_DE_LANE1 14'h05C5
`define SLDC_IDX_DE_LANE2 14'h05C6
`define SLDC_IDX_DE_LANE3 14'h05C7

// field positions
`define SLDC_SWING_HI 2
`define SLDC_SWING_LO 0
`define SLDC_DE_EN_BIT 7
`define SLDC_DE_LVL_HI 6
`define SLDC_DE_LVL_LO 4
`define SLDC_DE_RSV_HI 3
`define SLDC_DE_RSV_LO 0

// reset values
`define SLDC_SWING_RST 3'h1
`define SLDC_DE_RST 8'h00

// documented code limits
`define SLDC_SWING_MAX 3'h2
`define SLDC_LVL_MAX 3'h4

`endif

// >>> shared/sldc_pkg.sv
// types shared by the lane driver register bank
package sldc_pkg;

   typedef logic [2:0] sldc_swing_t;

   // post-tap setting of one lane, laid out as its register byte
   typedef struct packed {
      logic enable;
      logic [2:0] level;
      logic [3:0] rsvd;
   } sldc_deemph_s;

   typedef enum logic [2:0] {
      SLDC_SEL_NONE,
      SLDC_SEL_SWING6,
      SLDC_SEL_DE
   } sldc_sel_e;

endpackage : sldc_pkg

// >>> src/sldc_field_reg.sv
// one writable register field with a reset value and clock enable
module sldc_field_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic wen,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] q
);

   if (W < 1 || W > 32) begin : g_bad_w
      $error("sldc_field_reg: W out of range");
   end

   // any code is stored as written, undocumented ones included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= RST;
      end else if (clk_en && wen) begin
         q <= wdata;
      end
   end

endmodule : sldc_field_reg

// >>> src/sldc_regs.sv
// APB register bank for serial lane driver swing and de-emphasis
//
// Overview of operation
// - Lane 6 swing code sits in bits [2:0], resets to 001, and scales the supply swing.
// - Lane bytes hold post-tap level [6:4] (0..12 dB) and enable bit 7, both reset zero.
// - Index 0x05C4 drives lane 0, with read/write reserved bits [3:0] reset zero.
// - Indices 0x05C5 to 0x05C7 drive lanes 1 to 3 alike, all resetting to zero.
//
// Our own choice: register access over APB.
`include "sldc_consts.svh"

module sldc_regs #(
   parameter int ADDR_W = 16,
   parameter int NLANES = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output sldc_pkg::sldc_swing_t swing_lane6,
   output sldc_pkg::sldc_deemph_s [NLANES-1:0] deemph_lane
);
   import sldc_pkg::*;

   if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr_w
      $error("sldc_regs: ADDR_W must be 16 to 32");
   end
   if (NLANES != 4) begin : g_bad_nlanes
      $error("sldc_regs: only four de-emphasis lanes exist");
   end

   // index of a de-emphasis register for a lane
   function automatic logic [13:0] de_index(input int lane);
      de_index = `SLDC_IDX_DE_BASE + 14'(lane);
   endfunction : de_index

   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;

   // decode
   // shift keeps the upper-bit test legal when ADDR_W is 16
   wire logic aligned = (paddr[1:0] == 2'h0) && ((paddr >> 16) == '0);
   wire logic [13:0] reg_idx = paddr[15:2];
   wire logic hit_swing = aligned && (reg_idx == `SLDC_IDX_SWING6);
   wire logic [NLANES-1:0] hit_de;
   genvar g;
   generate
      for (g = 0; g < NLANES; g++) begin : g_hit
         assign hit_de[g] = aligned && (reg_idx == de_index(g));
      end
   endgenerate
   wire logic hit_any = hit_swing || (|hit_de);
   wire sldc_sel_e sel = hit_swing ? SLDC_SEL_SWING6 : ((|hit_de) ? SLDC_SEL_DE : SLDC_SEL_NONE);

   // access phase, first cycle: answer is prepared; second cycle: completes
   wire logic acc_first = psel && penable && !pready_r;
   wire logic acc_done = psel && penable && pready_r;
   wire logic wr_go = acc_done && pwrite && hit_any;

   // register storage
   logic [2:0] swing_q;
   logic [7:0] de_q [NLANES];

   sldc_field_reg #(
      .W(3),
      .RST(`SLDC_SWING_RST)
   ) u_swing6 (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .wen(wr_go && hit_swing),
      .wdata(pwdata[`SLDC_SWING_HI:`SLDC_SWING_LO]),
      .q(swing_q)
   );

   generate
      for (g = 0; g < NLANES; g++) begin : g_lane
         sldc_field_reg #(
            .W(8),
            .RST(`SLDC_DE_RST)
         ) u_de (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .wen(wr_go && hit_de[g]),
            .wdata(pwdata[7:0]),
            .q(de_q[g])
         );
         // enable bit 7, level [6:4], reserved [3:0]
         assign deemph_lane[g] = sldc_deemph_s'(de_q[g]);
      end
   endgenerate

   assign swing_lane6 = swing_q;

   // read mux: unused bits read zero
   logic [7:0] de_rd;
   always_comb begin
      de_rd = 8'h00;
      for (int i = 0; i < NLANES; i++) begin
         if (hit_de[i]) begin
            de_rd = de_q[i];
         end
      end
   end

   wire logic [31:0] rd_word =
      (sel == SLDC_SEL_SWING6) ? {29'h0000_0000, swing_q} :
      (sel == SLDC_SEL_DE) ? {24'h00_0000, de_rd} : 32'h0000_0000;

   assign prdata_nxt = (acc_first && !pwrite) ? rd_word : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_r <= acc_first;
         pslverr_r <= acc_first && !hit_any;
         prdata_r <= prdata_nxt;
      end
   end

   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign prdata = prdata_r;

   // checks
   a_swing_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> swing_lane6 == `SLDC_SWING_RST)
      else $error("swing code not 001 after reset");

   a_de_reset: assert property (@(posedge pclk)
      $rose(presetn) |-> deemph_lane == '0)
      else $error("de-emphasis registers not zero after reset");

   a_swing_write: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wr_go && hit_swing) |=> swing_lane6 == $past(pwdata[2:0]))
      else $error("swing write not stored");

   a_lane0_write: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wr_go && paddr == {`SLDC_IDX_DE_LANE0, 2'h0})
      |=> deemph_lane[0] == $past(pwdata[7:0]))
      else $error("lane 0 write not stored");

   a_lane3_fields: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wr_go && paddr == {`SLDC_IDX_DE_LANE3, 2'h0})
      |=> deemph_lane[3].enable == $past(pwdata[7])
          && deemph_lane[3].level == $past(pwdata[6:4]))
      else $error("lane 3 enable or level wrong");

   a_other_lanes: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && wr_go && paddr == {`SLDC_IDX_DE_LANE1, 2'h0})
      |=> deemph_lane[1] == $past(pwdata[7:0]) && $stable(deemph_lane[2])
          && $stable(deemph_lane[3]) && $stable(deemph_lane[0]))
      else $error("lane 1 write disturbed another lane");

   a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !(clk_en && wr_go) |=> $stable(deemph_lane) && $stable(swing_lane6))
      else $error("register changed without a write");

   a_read_back: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && acc_first && !pwrite && hit_de[2])
      |=> pready && prdata == {24'h00_0000, $past(de_q[2])})
      else $error("lane 2 read back wrong");

   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && pready) |=> !pready)
      else $error("pready held more than one cycle");

   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && acc_first && !hit_any) |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

endmodule : sldc_regs

// >>> sim/tb_serial_lane_driver_config_regs.sv
// self-checking bench for the lane driver register bank
module tb_serial_lane_driver_config_regs;
   timeunit 1ns;
   timeprecision 100ps;
   import sldc_pkg::*;
   localparam logic [15:0] A_SW = 16'h170C;
   localparam logic [15:0] A_DE = 16'h1710;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   sldc_swing_t swing_lane6;
   sldc_deemph_s [3:0] deemph_lane;
   int err_count, num_checks;

   sldc_regs dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .swing_lane6(swing_lane6), .deemph_lane(deemph_lane));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; only the watchdog ends a wait for pready
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [15:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
      chk("pslverr", 32'h0, 32'(err));
   endtask : rdchk

   task automatic t_reset;
      chk("swing port", 32'h1, 32'(swing_lane6));
      chk("deemph port", 32'h0, 32'(deemph_lane));
      rdchk(A_SW, 32'h1, "swing reg");
      for (int i = 0; i < 4; i++)
         rdchk(A_DE + 16'(4 * i), 32'h0, "deemph reg");
      $display("test reset done");
   endtask : t_reset

   task automatic t_swing;
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, A_SW, 32'hFFFF_FFF8 | 32'(c));
         repeat (2) @(negedge pclk);
         chk("swing port", 32'(c), 32'(swing_lane6));
         rdchk(A_SW, 32'(c), "swing reg");
      end
      $display("test swing done");
   endtask : t_swing

   task automatic t_deemph;
      logic [7:0] v [4];
      for (int p = 0; p < 2; p++) begin
         for (int l = 0; l < 4; l++) begin
            v[l] = {1'(l ^ p), 3'(p * 4 + l), 4'hA ^ 4'(l)};
            apb(1'b1, A_DE + 16'(4 * l), {24'hFF_FFFF, v[l]});
         end
         repeat (2) @(negedge pclk);
         for (int l = 0; l < 4; l++) begin
            chk("deemph port", 32'(v[l]), 32'(deemph_lane[l]));
            rdchk(A_DE + 16'(4 * l), 32'(v[l]), "deemph reg");
         end
      end
      $display("test deemph done");
   endtask : t_deemph

   task automatic t_unmapped;
      apb(1'b1, 16'h1708, 32'h0);
      chk("pslverr", 32'h1, 32'(err));
      apb(1'b1, 16'h1720, 32'h0);
      chk("pslverr", 32'h1, 32'(err));
      apb(1'b0, 16'h1712, 32'h0);
      chk("pslverr", 32'h1, 32'(err));
      chk("rdata", 32'h0, rd);
      rdchk(A_DE, 32'h0000_00CA, "deemph reg");
      rdchk(A_SW, 32'h7, "swing reg");
      $display("test unmapped done");
   endtask : t_unmapped

   // clock enable low in the access phase stretches it; the write lands later
   task automatic t_freeze;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= A_SW;
      pwdata <= 32'h0000_0002;
      @(posedge pclk);
      penable <= 1'b1;
      clk_en <= 1'b0;
      repeat (3) begin
         @(posedge pclk);
         chk("pready", 32'h0, 32'(pready));
      end
      chk("swing port", 32'h7, 32'(swing_lane6));
      clk_en <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(negedge pclk);
      chk("swing port", 32'h2, 32'(swing_lane6));
      $display("test freeze done");
   endtask : t_freeze

   // reset in mid-run brings every field back to its reset value
   task automatic t_rerst;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("swing port", 32'h1, 32'(swing_lane6));
      chk("deemph port", 32'h0, 32'(deemph_lane));
      presetn <= 1'b1;
      rdchk(A_SW, 32'h1, "swing reg");
      rdchk(A_DE + 16'h000C, 32'h0, "deemph reg");
      $display("test rerst done");
   endtask : t_rerst

   initial begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_swing;
      t_deemph;
      t_unmapped;
      t_freeze;
      t_rerst;
      give_verdict;
   end

   initial begin
      #20000;
      err_count++;
      give_verdict;
   end
endmodule : tb_serial_lane_driver_config_regs
